// ===== core/avr_pkg.sv
// Purpose: shared constants and types for the voltage result register bank
// Assumes: 8-bit register port, 16-bit two's-complement results, 1 mV lsb
// Notes: high byte of each channel sits one offset below its low byte
package avr_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int RES_W = 16;
	localparam int NUM_CH = 3;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_BUS_HIGH = 8'h1b;
	localparam logic [ADDR_W-1:0] OFS_BUS_LOW = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_BAT_HIGH = 8'h1d;
	localparam logic [ADDR_W-1:0] OFS_BAT_LOW = 8'h1e;
	localparam logic [ADDR_W-1:0] OFS_SYS_HIGH = 8'h1f;
	localparam logic [ADDR_W-1:0] OFS_SYS_LOW = 8'h20;

	// reset values and field layout
	localparam logic [RES_W-1:0] RESULT_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
	localparam int SIGN_BIT = 15;
	localparam int HIGH_MSB = 15;
	localparam int HIGH_LSB = 8;
	localparam int LOW_MSB = 7;
	localparam int LOW_LSB = 0;

	typedef enum logic [1:0] {
		AVR_CH_BUS = 2'h0,
		AVR_CH_BAT = 2'h1,
		AVR_CH_SYS = 2'h2,
		AVR_CH_NONE = 2'h3
	} avr_chan_t;

	localparam int CH_BUS = 0;
	localparam int CH_BAT = 1;
	localparam int CH_SYS = 2;

	// one converter result, valid for one cycle
	typedef struct packed {
		logic valid;
		avr_chan_t chan;
		logic [RES_W-1:0] value;
	} avr_sample_t;

	// one register port request
	typedef struct packed {
		logic rd_en;
		logic wr_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wr_data;
	} avr_req_t;

	typedef struct packed {
		logic hit;
		logic high;
		avr_chan_t chan;
	} avr_decode_t;

	function automatic avr_decode_t avr_decode(input logic [ADDR_W-1:0] addr);
		avr_decode_t d;
		d = '{hit: 1'b1, high: 1'b0, chan: AVR_CH_NONE};
		case (addr)
			OFS_BUS_HIGH: begin
				d.high = 1'b1;
				d.chan = AVR_CH_BUS;
			end
			OFS_BUS_LOW: d.chan = AVR_CH_BUS;
			OFS_BAT_HIGH: begin
				d.high = 1'b1;
				d.chan = AVR_CH_BAT;
			end
			OFS_BAT_LOW: d.chan = AVR_CH_BAT;
			OFS_SYS_HIGH: begin
				d.high = 1'b1;
				d.chan = AVR_CH_SYS;
			end
			OFS_SYS_LOW: d.chan = AVR_CH_SYS;
			default: d.hit = 1'b0;
		endcase
		return d;
	endfunction : avr_decode

endpackage : avr_pkg

// ===== core/avr_sample_capture.sv
// Purpose: holds one channel's latest 16-bit conversion result
// Assumes: load and clear come from logic on the same clock
// Notes: a result arriving with a register-reset command is kept
`timescale 1ns/10ps
`default_nettype none
module avr_sample_capture (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic [avr_pkg::RES_W-1:0] value_in,
	input wire logic clear_in,
	output logic [avr_pkg::RES_W-1:0] result_out
);

	// watchdog expiry is deliberately not an input here: it must not touch results
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			result_out <= avr_pkg::RESULT_RESET;
		end else if (load_in) begin
			// stored as delivered: two's complement, sign in bit 15
			result_out <= value_in;
		end else if (clear_in) begin
			result_out <= avr_pkg::RESULT_RESET;
		end
	end

endmodule : avr_sample_capture
`default_nettype wire

// ===== core/avr_result_regs.sv
// Purpose: read-only bank of bus, battery and system rail voltage results
// Assumes: converter and register port run on ref_clk_in, no crossing needed
// Notes: reading a high byte freezes that channel's low byte for the next read
`timescale 1ns/10ps
`default_nettype none
module avr_result_regs (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire avr_pkg::avr_sample_t sample_in,
	input wire avr_pkg::avr_req_t req_in,
	input wire logic reg_reset_cmd_in,
	input wire logic watchdog_expire_in,
	output logic [avr_pkg::DATA_W-1:0] rd_data_out,
	output logic rd_valid_out,
	output logic rd_hit_out,
	output logic wr_ack_out
);

	////////////////////////////////////////////////////////////////////////
	// result holding registers, one per channel

	logic [avr_pkg::NUM_CH-1:0][avr_pkg::RES_W-1:0] result;
	logic [avr_pkg::NUM_CH-1:0] load;

	genvar g;
	generate
		for (g = 0; g < avr_pkg::NUM_CH; g++) begin : gen_ch
			assign load[g] = sample_in.valid && (2'(sample_in.chan) == 2'(g));
			avr_sample_capture u_capture (
				.ref_clk_in(ref_clk_in),
				.rst_n_in(rst_n_in),
				.load_in(load[g]),
				.value_in(sample_in.value),
				.clear_in(reg_reset_cmd_in),
				.result_out(result[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// read decode

	avr_pkg::avr_decode_t dec;
	logic [1:0] ch;
	assign dec = avr_pkg::avr_decode(req_in.addr);
	assign ch = 2'(dec.chan);

	// low-byte snapshot so a high-then-low read pair is coherent even if a
	// new conversion lands between the two reads
	logic [avr_pkg::NUM_CH-1:0][avr_pkg::DATA_W-1:0] hold_low;
	logic [avr_pkg::NUM_CH-1:0] hold_valid;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hold_valid <= '0;
			hold_low <= '0;
		end else if (reg_reset_cmd_in) begin
			hold_valid <= '0;
		end else if (req_in.rd_en && dec.hit) begin
			if (dec.high) begin
				hold_low[ch] <= result[ch][avr_pkg::LOW_MSB:avr_pkg::LOW_LSB];
				hold_valid[ch] <= 1'b1;
			end else begin
				hold_valid[ch] <= 1'b0;
			end
		end
	end

	logic [avr_pkg::DATA_W-1:0] next_rd_data;

	always_comb begin
		next_rd_data = avr_pkg::UNMAPPED_READ;
		if (dec.hit) begin
			if (dec.high) begin
				// full high byte: bit 7 is the sign, bits 6..0 weigh 16384..256 mV
				next_rd_data = result[ch][avr_pkg::HIGH_MSB:avr_pkg::HIGH_LSB];
			end else if (hold_valid[ch]) begin
				next_rd_data = hold_low[ch];
			end else begin
				next_rd_data = result[ch][avr_pkg::LOW_MSB:avr_pkg::LOW_LSB];
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= avr_pkg::READ_IDLE;
			rd_valid_out <= 1'b0;
			rd_hit_out <= 1'b0;
		end else begin
			rd_valid_out <= req_in.rd_en;
			rd_hit_out <= req_in.rd_en && dec.hit;
			if (req_in.rd_en) begin
				rd_data_out <= next_rd_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// writes are acknowledged and dropped; nothing in this bank is writable

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ack_out <= 1'b0;
		end else begin
			wr_ack_out <= req_in.wr_en;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	sequence s_read_at(logic [avr_pkg::ADDR_W-1:0] a);
		req_in.rd_en && (req_in.addr == a);
	endsequence

	sequence s_bat_pair;
		(s_read_at(avr_pkg::OFS_BAT_HIGH) and !reg_reset_cmd_in)
		##1 (s_read_at(avr_pkg::OFS_BAT_LOW) and !reg_reset_cmd_in);
	endsequence

	a_read_latency: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		req_in.rd_en |=> rd_valid_out ##1 (rd_valid_out == $past(req_in.rd_en)))
		else $error("read answer not one cycle after request");

	a_bus_low_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_read_at(avr_pkg::OFS_BUS_LOW) and (hold_valid[avr_pkg::CH_BUS] == 1'b0)
		|=> rd_hit_out && (rd_data_out == $past(result[avr_pkg::CH_BUS][7:0])))
		else $error("bus low byte read wrong");

	a_bat_high_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_read_at(avr_pkg::OFS_BAT_HIGH)
		|=> rd_data_out[6:0] == $past(result[avr_pkg::CH_BAT][14:8]))
		else $error("battery high byte read wrong");

	a_bat_pair_coherent: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_bat_pair |=> rd_data_out == $past(result[avr_pkg::CH_BAT][7:0], 2))
		else $error("battery low byte not taken from high read");

	a_sys_high_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_read_at(avr_pkg::OFS_SYS_HIGH)
		|=> rd_data_out[6:0] == $past(result[avr_pkg::CH_SYS][14:8]))
		else $error("system high byte read wrong");

	a_sys_low_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_read_at(avr_pkg::OFS_SYS_LOW) and (hold_valid[avr_pkg::CH_SYS] == 1'b0)
		|=> rd_data_out == $past(result[avr_pkg::CH_SYS][7:0]))
		else $error("system low byte read wrong");

	a_sign_in_high: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		req_in.rd_en && dec.hit && dec.high
		|=> rd_data_out[7] == $past(result[ch][avr_pkg::SIGN_BIT]))
		else $error("sign bit not in high byte bit 7");

	a_bus_high_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_read_at(avr_pkg::OFS_BUS_HIGH)
		|=> rd_data_out == $past(result[avr_pkg::CH_BUS][15:8]))
		else $error("bus high byte read wrong");

	a_reset_cmd_clears: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		reg_reset_cmd_in && !sample_in.valid |=> (result == '0) && (hold_valid == '0))
		else $error("register reset left a result set");

	a_watchdog_keeps: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		watchdog_expire_in && !reg_reset_cmd_in && !sample_in.valid |=> $stable(result))
		else $error("watchdog expiry changed a result");

	a_write_ignored: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		req_in.wr_en && !req_in.rd_en && !reg_reset_cmd_in && !sample_in.valid
		|=> wr_ack_out && $stable(result) && $stable(hold_valid) && !rd_valid_out)
		else $error("write altered bank state");

endmodule : avr_result_regs
`default_nettype wire

// ===== verification/avr_host_model.sv
// Purpose: host side of the register port, issuing reads and writes
// Assumes: requests change on falling edges, the bank samples on rising edges
// Notes: a released address shows its inverse so stale values cannot pass
`timescale 1ns/10ps
`default_nettype none
module avr_host_model (
	input wire logic ref_clk_in,
	input wire logic [avr_pkg::DATA_W-1:0] rd_data_in,
	input wire logic rd_valid_in,
	input wire logic rd_hit_in,
	input wire logic wr_ack_in,
	output var avr_pkg::avr_req_t req_out
);
	initial begin
		req_out = '0;
	end
	//////////////////////////////////////////////////////////////////////////
	// one read: the answer is registered, so it is looked at one edge later
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
			output logic [1:0] flags);
		@(negedge ref_clk_in);
		req_out.rd_en = 1'b1;
		req_out.addr = addr;
		@(negedge ref_clk_in);
		req_out.rd_en = 1'b0;
		req_out.addr = ~addr;
		data = rd_data_in;
		flags = {rd_valid_in, rd_hit_in};
	endtask : read_reg
	// high then low byte of one channel on two consecutive edges, no idle cycle
	task automatic read_pair(input logic [7:0] addr, output logic [15:0] word);
		@(negedge ref_clk_in);
		req_out.rd_en = 1'b1;
		req_out.addr = addr;
		@(negedge ref_clk_in);
		req_out.addr = addr + 8'h01;
		word[15:8] = rd_data_in;
		@(negedge ref_clk_in);
		req_out.rd_en = 1'b0;
		req_out.addr = ~addr;
		word[7:0] = rd_data_in;
	endtask : read_pair
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data,
			output logic ack);
		@(negedge ref_clk_in);
		req_out.wr_en = 1'b1;
		req_out.addr = addr;
		req_out.wr_data = data;
		@(negedge ref_clk_in);
		req_out.wr_en = 1'b0;
		req_out.addr = ~addr;
		req_out.wr_data = ~data;
		ack = wr_ack_in;
	endtask : write_reg
endmodule : avr_host_model
`default_nettype wire

// ===== verification/tb_avr_result_regs.sv
// Purpose: self-checking bench for the voltage result register bank
// Assumes: the host model owns the register port, the bench owns the rest
// Notes: every pair is read high byte first, as the snapshot expects
`timescale 1ns/10ps
`default_nettype none
module tb_avr_result_regs;
	logic ref_clk_in;
	logic rst_n_in;
	avr_pkg::avr_sample_t sample;
	avr_pkg::avr_req_t req;
	logic reg_reset_cmd;
	logic watchdog_expire;
	logic [7:0] rd_data;
	logic rd_valid;
	logic rd_hit;
	logic wr_ack;
	logic [7:0] data;
	logic [1:0] flags;
	logic ack;
	logic [15:0] pair;
	int n_errors = 0;
	int n_checks = 0;
	// 10 V, 8 V and a negative reading to exercise the sign
	logic [15:0] vals [3] = '{16'h2710, 16'h1f40, 16'hfc18};

	avr_result_regs dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sample_in(sample),
		.req_in(req), .reg_reset_cmd_in(reg_reset_cmd), .watchdog_expire_in(watchdog_expire),
		.rd_data_out(rd_data), .rd_valid_out(rd_valid), .rd_hit_out(rd_hit),
		.wr_ack_out(wr_ack));
	avr_host_model host_u (.ref_clk_in(ref_clk_in), .rd_data_in(rd_data),
		.rd_valid_in(rd_valid), .rd_hit_in(rd_hit), .wr_ack_in(wr_ack), .req_out(req));
	//////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		if (n_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	task automatic load(input int ch, input logic [15:0] value);
		@(negedge ref_clk_in);
		sample = '{valid: 1'b1, chan: avr_pkg::avr_chan_t'(ch), value: value};
		@(negedge ref_clk_in);
		sample.valid = 1'b0;
	endtask : load
	// reads all six bytes, high then low, against the table or zero
	task automatic check_bank(input logic keep);
		logic [15:0] exp;
		for (int ch = 0; ch < 3; ch++) begin
			exp = keep ? vals[ch] : 16'h0000;
			host_u.read_reg(avr_pkg::OFS_BUS_HIGH + 8'(2 * ch), data, flags);
			check(data, exp[15:8]);
			check({6'h00, flags}, 8'h03);
			host_u.read_reg(avr_pkg::OFS_BUS_LOW + 8'(2 * ch), data, flags);
			check(data, exp[7:0]);
			check({6'h00, flags}, 8'h03);
		end
	endtask : check_bank
	//////////////////////////////////////////////////////////////////////////
	initial begin
		#20000;
		n_errors++;
		finish_test();
	end
	initial begin
		rst_n_in = 1'b0;
		sample = '0;
		reg_reset_cmd = 1'b0;
		watchdog_expire = 1'b0;
		repeat (5) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		rst_n_in = 1'b1;
		check_bank(1'b0);
		for (int ch = 0; ch < 3; ch++) begin
			load(ch, vals[ch]);
		end
		// the spare channel code must not land anywhere
		load(3, 16'hffff);
		check_bank(1'b1);
		// a new battery result lands between the back-to-back halves of a pair read
		fork
			host_u.read_pair(avr_pkg::OFS_BAT_HIGH, pair);
			load(avr_pkg::CH_BAT, 16'h1234);
		join
		check(pair[15:8], vals[1][15:8]);
		check(pair[7:0], vals[1][7:0]);
		host_u.read_pair(avr_pkg::OFS_BAT_HIGH, pair);
		check(pair[15:8], 8'h12);
		check(pair[7:0], 8'h34);
		load(avr_pkg::CH_BAT, vals[1]);
		host_u.read_reg(8'h21, data, flags);
		check(data, 8'h00);
		check({6'h00, flags}, 8'h02);
		for (int a = 8'h1b; a <= 8'h20; a++) begin
			host_u.write_reg(8'(a), 8'hff, ack);
			check({7'h00, ack}, 8'h01);
		end
		check_bank(1'b1);
		@(negedge ref_clk_in);
		watchdog_expire = 1'b1;
		@(negedge ref_clk_in);
		watchdog_expire = 1'b0;
		check_bank(1'b1);
		// a snapshot taken before a register reset must not survive it
		host_u.read_reg(avr_pkg::OFS_SYS_HIGH, data, flags);
		check(data, vals[2][15:8]);
		@(negedge ref_clk_in);
		reg_reset_cmd = 1'b1;
		@(negedge ref_clk_in);
		reg_reset_cmd = 1'b0;
		host_u.read_reg(avr_pkg::OFS_SYS_LOW, data, flags);
		check(data, 8'h00);
		check_bank(1'b0);
		// second reset in mid-run, with every result loaded
		for (int ch = 0; ch < 3; ch++) begin
			load(ch, vals[ch]);
		end
		@(negedge ref_clk_in);
		rst_n_in = 1'b0;
		@(negedge ref_clk_in);
		rst_n_in = 1'b1;
		check_bank(1'b0);
		finish_test();
	end
endmodule : tb_avr_result_regs
`default_nettype wire
